// File: ict_mem_model.sv
// Memory side model inserting wait states through the stall enable
`timescale 1ns/1ps
`default_nettype none
module ict_mem_model (
	input  wire logic mclk,
	input  wire logic slow,
	output logic      mem_ready
);
	int unsigned phase = 0;
	initial mem_ready = 1'b1;
	// Slow memory stalls one cycle in three
	always @(negedge mclk) begin
		phase <= (phase + 1) % 3;
		mem_ready <= !(slow && phase == 0);
	end
endmodule
`default_nettype wire

// File: ict_pkg.sv
// Constants and types for the execute-stage cycle timing model
package ict_pkg;

	typedef enum logic [1:0] {
		ICT_CYC_S,
		ICT_CYC_N,
		ICT_CYC_I,
		ICT_CYC_C
	} ict_cyc_t;

	typedef enum logic [2:0] {
		ICT_DATA_OP,
		ICT_SINGLE_WORD_LOAD,
		ICT_DOUBLEWORD_LOAD,
		ICT_MULTI_REGISTER_LOAD,
		ICT_MULTI_REGISTER_STORE,
		ICT_ATOMIC_SWAP,
		ICT_COPROC_TO_CORE_TRANSFER
	} ict_class_t;

	localparam int ICT_CNT_W         = 8;
	localparam int ICT_WORDS_W       = 5;
	localparam int ICT_BUSY_W        = 6;
	localparam logic [7:0] ICT_ZERO  = 8'h00;
	localparam logic [7:0] ICT_ONE   = 8'h01;
	localparam logic [7:0] ICT_TWO   = 8'h02;
	localparam logic [7:0] ICT_PC_I  = 8'h04;

endpackage

// File: ict_timing.sv
// Execute-stage cycle timing sequencer with one-cycle-ahead bus type announce
`timescale 1ns/1ps
`default_nettype none
module ict_timing #(
	parameter int WORDS_W = ict_pkg::ICT_WORDS_W,
	parameter int BUSY_W  = ict_pkg::ICT_BUSY_W
) (
	input  wire logic                      mclk,
	input  wire logic                      nrst,
	input  wire logic                      clock_stall_enable,
	input  wire logic                      issue_valid,
	output logic                           issue_ready,
	input  wire ict_pkg::ict_class_t       issue_class,
	input  wire logic                      pc_dest,
	input  wire logic                      reg_shift,
	input  wire logic                      next_uses,
	input  wire logic                      narrow_load,
	input  wire logic [WORDS_W-1:0]        word_count,
	input  wire logic [BUSY_W-1:0]         busy_waits,
	output logic                           exec_active,
	output logic                           exec_last,
	output logic [ict_pkg::ICT_CNT_W-1:0]  exec_step,
	output logic                           announce_valid,
	output ict_pkg::ict_cyc_t              ibus_cycle,
	output ict_pkg::ict_cyc_t              dbus_cycle
);

	localparam int CW = ict_pkg::ICT_CNT_W;

	typedef enum logic [1:0] {ICT_IDLE, ICT_LEAD, ICT_EXEC} ict_state_t;

	////////////////////////////////////////////////////////////////////////
	// Bus type of one step from segment lengths
	function automatic ict_pkg::ict_cyc_t ibus_kind(input logic [CW-1:0] k,
		input logic [CW-1:0] ls, input logic [CW-1:0] ni, input logic [CW-1:0] nn);
		if (k < ls) begin
			ibus_kind = ict_pkg::ICT_CYC_S;
		end else if (k < CW'(ls + ni)) begin
			ibus_kind = ict_pkg::ICT_CYC_I;
		end else if (k < CW'(ls + ni + nn)) begin
			ibus_kind = ict_pkg::ICT_CYC_N;
		end else begin
			ibus_kind = ict_pkg::ICT_CYC_S;
		end
	endfunction

	function automatic ict_pkg::ict_cyc_t dbus_kind(input logic [CW-1:0] k,
		input logic [CW-1:0] li, input logic [CW-1:0] dn, input logic [CW-1:0] ds,
		input logic [CW-1:0] ti);
		if (k < li) begin
			dbus_kind = ict_pkg::ICT_CYC_I;
		end else if (k < CW'(li + dn)) begin
			dbus_kind = ict_pkg::ICT_CYC_N;
		end else if (k < CW'(li + dn + ds)) begin
			dbus_kind = ict_pkg::ICT_CYC_S;
		end else if (k < CW'(li + dn + ds + ti)) begin
			dbus_kind = ict_pkg::ICT_CYC_I;
		end else begin
			dbus_kind = ict_pkg::ICT_CYC_C;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// State
	ict_state_t    state;
	logic [CW-1:0] step, total;
	logic [CW-1:0] i_ls, i_ni, i_nn;
	logic [CW-1:0] d_li, d_n, d_s, d_ti;

	////////////////////////////////////////////////////////////////////////
	// Per-class segment decode at issue
	logic [CW-1:0] c_ls, c_ni, c_nn, c_li, c_n, c_s, c_ti, c_c, c_total;
	logic [CW-1:0] words, waits, use_i, ld_i;
	assign words = CW'(word_count);
	assign waits = CW'(busy_waits);
	assign use_i = next_uses ? ict_pkg::ICT_ONE : ict_pkg::ICT_ZERO;
	assign ld_i  = !next_uses ? ict_pkg::ICT_ZERO :
		(narrow_load ? ict_pkg::ICT_TWO : ict_pkg::ICT_ONE);

	always_comb begin
		c_ls = ict_pkg::ICT_ZERO;
		c_ni = ict_pkg::ICT_ZERO;
		c_nn = ict_pkg::ICT_ZERO;
		c_li = ict_pkg::ICT_ZERO;
		c_n  = ict_pkg::ICT_ZERO;
		c_s  = ict_pkg::ICT_ZERO;
		c_ti = ict_pkg::ICT_ZERO;
		c_c  = ict_pkg::ICT_ZERO;
		unique case (issue_class)
			ict_pkg::ICT_DATA_OP: begin
				c_li = CW'(ict_pkg::ICT_ONE + (reg_shift ? ict_pkg::ICT_ONE : ict_pkg::ICT_ZERO)
					+ (pc_dest ? ict_pkg::ICT_TWO : ict_pkg::ICT_ZERO));
			end
			ict_pkg::ICT_SINGLE_WORD_LOAD: begin
				c_n  = ict_pkg::ICT_ONE;
				c_ti = pc_dest ? ict_pkg::ICT_PC_I : ld_i;
			end
			ict_pkg::ICT_DOUBLEWORD_LOAD: begin
				c_n  = ict_pkg::ICT_ONE;
				c_s  = ict_pkg::ICT_ONE;
				c_ti = use_i;
			end
			ict_pkg::ICT_MULTI_REGISTER_LOAD: begin
				if (pc_dest) begin
					c_n  = ict_pkg::ICT_ONE;
					c_s  = CW'(words - ict_pkg::ICT_ONE);
					c_ti = ict_pkg::ICT_PC_I;
				end else if (words == ict_pkg::ICT_ONE) begin
					c_s  = ict_pkg::ICT_ONE;
					c_ti = ict_pkg::ICT_ONE;
				end else begin
					c_n  = ict_pkg::ICT_ONE;
					c_s  = CW'(words - ict_pkg::ICT_ONE);
					c_ti = use_i;
				end
			end
			ict_pkg::ICT_MULTI_REGISTER_STORE: begin
				c_n  = ict_pkg::ICT_ONE;
				if (words == ict_pkg::ICT_ONE) begin
					c_ti = ict_pkg::ICT_ONE;
				end else begin
					c_s  = CW'(words - ict_pkg::ICT_ONE);
				end
			end
			ict_pkg::ICT_ATOMIC_SWAP: begin
				c_n  = ict_pkg::ICT_TWO;
				c_ti = use_i;
			end
			ict_pkg::ICT_COPROC_TO_CORE_TRANSFER: begin
				c_li = CW'(waits + use_i);
				c_c  = ict_pkg::ICT_ONE;
			end
			default: begin
				c_li = ict_pkg::ICT_ONE;
			end
		endcase
		c_total = CW'(c_li + c_n + c_s + c_ti + c_c);
		if (pc_dest && (issue_class != ict_pkg::ICT_ATOMIC_SWAP)
			&& (issue_class != ict_pkg::ICT_DOUBLEWORD_LOAD)
			&& (issue_class != ict_pkg::ICT_MULTI_REGISTER_STORE)
			&& (issue_class != ict_pkg::ICT_COPROC_TO_CORE_TRANSFER)) begin
			c_ls = ict_pkg::ICT_ZERO;
			c_nn = ict_pkg::ICT_ONE;
			c_ni = CW'(c_total - ict_pkg::ICT_TWO - ict_pkg::ICT_ONE);
		end else begin
			c_ls = ict_pkg::ICT_ONE;
			c_nn = ict_pkg::ICT_ZERO;
			c_ni = CW'(c_total - ict_pkg::ICT_ONE);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencing; stall enable low freezes everything
	logic       is_last, accept;
	ict_state_t next_state;
	logic [CW-1:0] next_step, next_total;
	logic [CW-1:0] next_ls, next_ni, next_nn, next_li, next_n, next_s, next_ti;
	logic [CW-1:0] next_k;
	logic          next_ann;

	assign is_last     = (state == ICT_EXEC) && (CW'(step + ict_pkg::ICT_ONE) == total);
	assign issue_ready = clock_stall_enable && ((state == ICT_IDLE) || is_last);
	assign accept      = issue_valid && issue_ready;
	assign exec_active = (state == ICT_EXEC);
	assign exec_last   = is_last;

	assign next_state = !clock_stall_enable ? state :
		accept ? ICT_LEAD :
		(state == ICT_LEAD) ? ICT_EXEC :
		is_last ? ICT_IDLE : state;
	assign next_step  = (!clock_stall_enable || state == ICT_IDLE) ? step :
		(state == ICT_LEAD || accept || is_last) ? ict_pkg::ICT_ZERO :
		CW'(step + ict_pkg::ICT_ONE);
	assign next_total = accept ? c_total : total;
	assign next_ls    = accept ? c_ls : i_ls;
	assign next_ni    = accept ? c_ni : i_ni;
	assign next_nn    = accept ? c_nn : i_nn;
	assign next_li    = accept ? c_li : d_li;
	assign next_n     = accept ? c_n  : d_n;
	assign next_s     = accept ? c_s  : d_s;
	assign next_ti    = accept ? c_ti : d_ti;

	// Announce the step that executes one cycle after the next one
	assign next_k   = (next_state == ICT_LEAD) ? ict_pkg::ICT_ZERO :
		CW'(next_step + ict_pkg::ICT_ONE);
	assign next_ann = (next_state == ICT_LEAD) ||
		((next_state == ICT_EXEC) && (next_k < next_total));

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state <= ICT_IDLE;
			step  <= ict_pkg::ICT_ZERO;
			total <= ict_pkg::ICT_ZERO;
			i_ls  <= ict_pkg::ICT_ZERO;
			i_ni  <= ict_pkg::ICT_ZERO;
			i_nn  <= ict_pkg::ICT_ZERO;
			d_li  <= ict_pkg::ICT_ZERO;
			d_n   <= ict_pkg::ICT_ZERO;
			d_s   <= ict_pkg::ICT_ZERO;
			d_ti  <= ict_pkg::ICT_ZERO;
		end else begin
			state <= next_state;
			step  <= next_step;
			total <= next_total;
			i_ls  <= next_ls;
			i_ni  <= next_ni;
			i_nn  <= next_nn;
			d_li  <= next_li;
			d_n   <= next_n;
			d_s   <= next_s;
			d_ti  <= next_ti;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registered announce outputs
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			announce_valid <= 1'b0;
			ibus_cycle     <= ict_pkg::ICT_CYC_I;
			dbus_cycle     <= ict_pkg::ICT_CYC_I;
			exec_step      <= ict_pkg::ICT_ZERO;
		end else begin
			announce_valid <= next_ann;
			ibus_cycle     <= next_ann ? ibus_kind(next_k, next_ls, next_ni, next_nn)
				: ict_pkg::ICT_CYC_I;
			dbus_cycle     <= next_ann ? dbus_kind(next_k, next_li, next_n, next_s, next_ti)
				: ict_pkg::ICT_CYC_I;
			exec_step      <= next_step;
		end
	end

endmodule
`default_nettype wire

// File: ict_timing_assertions.sv
// Concurrent checks on the cycle timing sequencer ports
`timescale 1ns/1ps
`default_nettype none
module ict_timing_assertions #(
	parameter int WORDS_W = ict_pkg::ICT_WORDS_W,
	parameter int BUSY_W  = ict_pkg::ICT_BUSY_W
) (
	input wire logic                          mclk,
	input wire logic                          nrst,
	input wire logic                          clock_stall_enable,
	input wire logic                          issue_valid,
	input wire logic                          issue_ready,
	input wire ict_pkg::ict_class_t           issue_class,
	input wire logic                          pc_dest,
	input wire logic                          reg_shift,
	input wire logic                          exec_active,
	input wire logic                          exec_last,
	input wire logic [ict_pkg::ICT_CNT_W-1:0] exec_step,
	input wire logic                          announce_valid,
	input wire ict_pkg::ict_cyc_t             dbus_cycle
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	sequence s_take;
		issue_valid && issue_ready;
	endsequence
	sequence s_plain;
		s_take ##0 (issue_class == ict_pkg::ICT_DATA_OP && !pc_dest && !reg_shift);
	endsequence
	sequence s_load;
		s_take ##0 (issue_class == ict_pkg::ICT_SINGLE_WORD_LOAD);
	endsequence
	chk_take_lead: assert property (s_take |=> announce_valid && !exec_active && !issue_ready)
		else $error("no lead cycle after accept");
	chk_lead_step: assert property (announce_valid && !exec_active && clock_stall_enable
		|=> exec_active && exec_step == 0) else $error("lead not followed by step 0");
	chk_stall_hold: assert property (!clock_stall_enable |=> $stable(exec_step)
		&& $stable(dbus_cycle) && $stable(announce_valid)) else $error("moved during stall");
	chk_step_count: assert property (exec_active && !exec_last && clock_stall_enable
		|=> exec_step == $past(exec_step) + 1) else $error("step index skipped");
	chk_last_quiet: assert property (exec_last |-> !announce_valid)
		else $error("announce in last step");
	chk_ahead_valid: assert property (exec_active && !exec_last |-> announce_valid)
		else $error("no announce ahead of next step");
	chk_last_idle: assert property (exec_last && clock_stall_enable && !issue_valid
		|=> !exec_active && !announce_valid) else $error("execute ran past last");
	chk_plain_one: assert property (s_plain ##1 clock_stall_enable |=> exec_last && exec_step == 0)
		else $error("plain data op not one cycle");
	chk_load_first: assert property (s_load |=> dbus_cycle == ict_pkg::ICT_CYC_N)
		else $error("word load not opened by N");
endmodule
bind ict_timing ict_timing_assertions #(.WORDS_W(WORDS_W), .BUSY_W(BUSY_W)) chk_i (
	.mclk(mclk), .nrst(nrst), .clock_stall_enable(clock_stall_enable),
	.issue_valid(issue_valid), .issue_ready(issue_ready), .issue_class(issue_class),
	.pc_dest(pc_dest), .reg_shift(reg_shift), .exec_active(exec_active),
	.exec_last(exec_last), .exec_step(exec_step), .announce_valid(announce_valid),
	.dbus_cycle(dbus_cycle));
`default_nettype wire

// File: ict_timing_tb_top.sv
// Self-checking bench for the cycle timing sequencer
`timescale 1ns/1ps
`default_nettype none
module ict_timing_tb_top;
	logic mclk = 1'b0, nrst = 1'b0, slow = 1'b0, stall_en, ready, active, last, avalid;
	logic ivalid = 1'b0, pc = 1'b0, rsh = 1'b0, uses = 1'b0, narrow = 1'b0;
	ict_pkg::ict_class_t cls = ict_pkg::ICT_DATA_OP;
	ict_pkg::ict_cyc_t   dbus, ibus;
	logic [4:0]          nwords = 5'h01;
	logic [5:0]          nbusy = 6'h00;
	logic [31:0]         seed = 32'h3741;
	ict_pkg::ict_cyc_t   exp_q[$], obs_q[$], iexp_q[$], iobs_q[$];
	int                  fails = 0, cmp_count = 0, exec_cnt = 0;
	always #10 mclk = ~mclk;
	ict_mem_model ict_mem_model_i (.mclk(mclk), .slow(slow), .mem_ready(stall_en));
	ict_timing ict_timing_i (.mclk(mclk), .nrst(nrst), .clock_stall_enable(stall_en),
		.issue_valid(ivalid), .issue_ready(ready), .issue_class(cls), .pc_dest(pc),
		.reg_shift(rsh), .next_uses(uses), .narrow_load(narrow), .word_count(nwords),
		.busy_waits(nbusy), .exec_active(active), .exec_last(last), .exec_step(),
		.announce_valid(avalid), .ibus_cycle(ibus), .dbus_cycle(dbus));
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic put(input ict_pkg::ict_cyc_t t, input int k);
		repeat (k) exp_q.push_back(t);
	endtask
	task automatic put_i(input ict_pkg::ict_cyc_t t, input int k);
		repeat (k) iexp_q.push_back(t);
	endtask
	task automatic cmp_icyc(input ict_pkg::ict_cyc_t got, input ict_pkg::ict_cyc_t exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("FAIL %0t instruction bus type %0d expected %0d", $time, got, exp);
		end
	endtask
	task automatic cmp_cyc(input ict_pkg::ict_cyc_t got, input ict_pkg::ict_cyc_t exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("FAIL %0t data bus type %0d expected %0d", $time, got, exp);
		end
	endtask
	task automatic cmp_cnt(input int got, input int exp);
		cmp_count++;
		if (got != exp) begin
			fails++;
			$display("FAIL %0t execute cycles %0d expected %0d", $time, got, exp);
		end
	endtask
	task automatic conclude();
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// Expected data bus sequence in order lead I, N, S, tail I, C
	task automatic build(input int n, input int b);
		exp_q.delete();
		case (cls)
			ict_pkg::ICT_DATA_OP: put(ict_pkg::ICT_CYC_I, (pc ? 3 : 1) + rsh);
			ict_pkg::ICT_SINGLE_WORD_LOAD: begin
				put(ict_pkg::ICT_CYC_N, 1);
				put(ict_pkg::ICT_CYC_I, pc ? 4 : (uses ? 1 + narrow : 0));
			end
			ict_pkg::ICT_DOUBLEWORD_LOAD: begin
				put(ict_pkg::ICT_CYC_N, 1);
				put(ict_pkg::ICT_CYC_S, 1);
				put(ict_pkg::ICT_CYC_I, uses);
			end
			ict_pkg::ICT_MULTI_REGISTER_LOAD: begin
				put(ict_pkg::ICT_CYC_N, (n > 1 || pc) ? 1 : 0);
				put(ict_pkg::ICT_CYC_S, (n > 1 || pc) ? n - 1 : 1);
				put(ict_pkg::ICT_CYC_I, pc ? 4 : (n == 1 ? 1 : uses));
			end
			ict_pkg::ICT_MULTI_REGISTER_STORE: begin
				put(ict_pkg::ICT_CYC_N, 1);
				put(ict_pkg::ICT_CYC_S, n - 1);
				put(ict_pkg::ICT_CYC_I, n == 1);
			end
			ict_pkg::ICT_ATOMIC_SWAP: begin
				put(ict_pkg::ICT_CYC_N, 2);
				put(ict_pkg::ICT_CYC_I, uses);
			end
			default: begin
				put(ict_pkg::ICT_CYC_I, b + uses);
				put(ict_pkg::ICT_CYC_C, 1);
			end
		endcase
		iexp_q.delete();
		if (pc && (cls == ict_pkg::ICT_DATA_OP || cls == ict_pkg::ICT_SINGLE_WORD_LOAD
			|| cls == ict_pkg::ICT_MULTI_REGISTER_LOAD)) begin
			put_i(ict_pkg::ICT_CYC_I, exp_q.size() - 3);
			put_i(ict_pkg::ICT_CYC_N, 1);
			put_i(ict_pkg::ICT_CYC_S, 2);
		end else begin
			put_i(ict_pkg::ICT_CYC_S, 1);
			put_i(ict_pkg::ICT_CYC_I, exp_q.size() - 1);
		end
	endtask
	always @(posedge mclk) begin
		if (nrst && stall_en && avalid) begin
			obs_q.push_back(dbus);
			iobs_q.push_back(ibus);
		end
		if (nrst && stall_en && active) exec_cnt++;
	end
	task automatic run_one(input int c);
		@(negedge mclk);
		cls = ict_pkg::ict_class_t'(c);
		{pc, rsh, uses, narrow} = 4'(rnd());
		nwords = 5'(rnd() % 16 + 1);
		nbusy = 6'(rnd());
		build(int'(nwords), int'(nbusy));
		obs_q.delete();
		iobs_q.delete();
		exec_cnt = 0;
		ivalid = 1'b1;
		@(posedge mclk);
		for (int i = 0; i < 20 && ready !== 1'b1; i++) @(posedge mclk);
		@(negedge mclk);
		ivalid = 1'b0;
		for (int i = 0; i < 300 && (active || avalid); i++) @(negedge mclk);
		cmp_cnt(exec_cnt, exp_q.size());
		cmp_cnt(obs_q.size(), exp_q.size());
		foreach (exp_q[i]) cmp_cyc(obs_q[i], exp_q[i]);
		cmp_cnt(iobs_q.size(), iexp_q.size());
		foreach (iexp_q[i]) cmp_icyc(iobs_q[i], iexp_q[i]);
	endtask
	initial begin
		repeat (10) @(posedge mclk);
		@(negedge mclk) nrst = 1'b1;
		for (int k = 0; k < 80; k++) begin
			slow = k >= 40;
			run_one(k < 7 ? k : int'(rnd() % 7));
		end
		conclude();
	end
	initial begin
		#400000;
		fails++;
		conclude();
	end
endmodule
`default_nettype wire
